// ==== logic/crg_mon_if.sv ====
// interface carrying supply monitor results to the top
// assumes single clock domain
`timescale 1ns/100ps
`default_nettype none
interface crg_mon_if;
   logic supply_ok;
   logic ref_ok;
   logic ana_ok;
   modport mon (output supply_ok, output ref_ok, output ana_ok);
   modport top (input supply_ok, input ref_ok, input ana_ok);
endinterface
`default_nettype wire

// ==== logic/crg_pkg.sv ====
// types for the chip reset generation block
// assumes crg_regs.svh constants
package crg_pkg;
   typedef enum logic [1:0]
   {
      CRG_RESET,
      CRG_CLKEN,
      CRG_BOOT,
      CRG_RUN
   } crg_state_e;
endpackage

// ==== logic/crg_regs.svh ====
// constants for the chip reset generation block
// assumes a 250 MHz core clock and a slow analog supply monitor
// Summary of operation
// - hardware reset is pin AND supply_ok
// - reset returns all key state to initial
// - supply_ok low until 8ms, 4ms met and core above 900mV
// - global reset spares the rtc domain
// - on release enable clock, then boot
// - rtc por initialises and sets power-lost flag
// - cpu reset and per-peripheral software resets
// - reset overrides pin mux with fixed behaviours
// - memory strobes, spi cs3, flag, reserved [5:4] high
// - clock_output and spi cs1 keep toggling
// - synchronous 0-1, 1-0, x-1, x-0 transitions
`ifndef CRG_REGS_SVH
`define CRG_REGS_SVH
`define CRG_CLK_MHZ        250
`define CRG_REF_MS         8
`define CRG_ANA_MS         4
`define CRG_CORE_MV        900
`define CRG_REF_CYC        (`CRG_REF_MS * 1000 * `CRG_CLK_MHZ)
`define CRG_ANA_CYC        (`CRG_ANA_MS * 1000 * `CRG_CLK_MHZ)
`define CRG_SYNC_STAGES    3
`define CRG_PIN_MIN_CYC    3
`define CRG_CLKEN_CYC      4
`define CRG_NUM_PERIPH     8
`define CRG_ADDR_W         21
`define CRG_BANK_W         2
`define CRG_MV_W           12
`endif

// ==== logic/crg_supply_mon.sv ====
// main power-on supply monitor producing supply_ok
// assumes level inputs already synchronised to clk
`timescale 1ns/100ps
`default_nettype none
`include "crg_regs.svh"
module crg_supply_mon
   import crg_pkg::*;
#(
   parameter int unsigned REF_CYC = `CRG_REF_CYC,
   parameter int unsigned ANA_CYC = `CRG_ANA_CYC
)
(
   // clock
   input  wire logic                 clk,
   // supply conditions
   input  wire logic                 ref_active,
   input  wire logic                 ana_present,
   input  wire logic [`CRG_MV_W-1:0] core_regulator_output,
   // results
   crg_mon_if.mon                    mon
);
   logic [31:0] ref_cnt_r;
   logic [31:0] ana_cnt_r;

   // reference active time, restarts when it drops
   always_ff @(posedge clk)
   begin
      if (!ref_active)
         ref_cnt_r <= 32'h0;
      else if (ref_cnt_r < REF_CYC)
         ref_cnt_r <= ref_cnt_r + 32'h1;
   end

   // analog supply present time
   always_ff @(posedge clk)
   begin
      if (!ana_present)
         ana_cnt_r <= 32'h0;
      else if (ana_cnt_r < ANA_CYC)
         ana_cnt_r <= ana_cnt_r + 32'h1;
   end

   // all three conditions gate supply_ok
   assign mon.ref_ok    = ref_active && (ref_cnt_r >= REF_CYC);
   assign mon.ana_ok    = ana_present && (ana_cnt_r >= ANA_CYC);
   assign mon.supply_ok = mon.ref_ok && mon.ana_ok &&
      (core_regulator_output > `CRG_MV_W'(`CRG_CORE_MV));
endmodule
`default_nettype wire

// ==== logic/crg_top.sv ====
// chip reset generation: combined reset, release sequence, reset pin states
// assumes clk free running; reset_pin_n and rtc_por_n are asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "crg_regs.svh"
module crg_top
   import crg_pkg::*;
#(
   parameter int unsigned REF_CYC = `CRG_REF_CYC,
   parameter int unsigned ANA_CYC = `CRG_ANA_CYC
)
(
   // clock and local reset
   input  wire logic                      clk,
   input  wire logic                      reset,
   // board reset pin and supply status
   input  wire logic                      reset_pin_n,
   input  wire logic                      ref_active,
   input  wire logic                      ana_present,
   input  wire logic [`CRG_MV_W-1:0]      core_regulator_output,
   // rtc domain
   input  wire logic                      rtc_por_n,
   input  wire logic                      rtc_flag_clear,
   output logic                           rtc_power_lost_flag,
   // software resets
   input  wire logic                      cpu_reset_instr,
   input  wire logic [`CRG_NUM_PERIPH-1:0] periph_reset_ctl,
   output logic                           cpu_reset_n,
   output logic [`CRG_NUM_PERIPH-1:0]     periph_reset_n,
   // chip reset and sequence
   output logic                           supply_ok,
   output logic                           hw_reset_n,
   output logic                           chip_reset_n,
   output logic                           core_clk_en,
   output logic                           boot_start,
   // normal pin values from the muxes
   input  wire logic                      fn_clock_output,
   input  wire logic                      fn_ext_mem_strobes,
   input  wire logic [3:0]                fn_ext_mem_cs_n,
   input  wire logic [`CRG_ADDR_W-1:0]    fn_ext_mem_addr,
   input  wire logic [`CRG_BANK_W-1:0]    fn_ext_mem_bank_addr,
   input  wire logic [3:0]                fn_spi_cs_n,
   input  wire logic                      fn_external_flag_out,
   // pads during reset
   output logic [3:0]                     ext_mem_cs_n,
   output logic [1:0]                     ext_mem_byte_mask_n,
   output logic                           ext_mem_oe_n,
   output logic                           ext_mem_we_n,
   output logic [`CRG_ADDR_W-1:0]         ext_mem_addr,
   output logic [`CRG_BANK_W-1:0]         ext_mem_bank_addr,
   output logic [3:0]                     spi_cs_n,
   output logic                           external_flag_out,
   output logic                           clock_output,
   output logic [5:0]                     rsv_out,
   output logic                           pins_in_reset
);
   crg_mon_if mon_if();
   logic [1:0] pin_sync_r;
   logic [`CRG_SYNC_STAGES-1:0] rel_sync_r;
   logic [1:0] rtc_sync_r;
   logic [1:0] pin_lo_cnt_r;
   logic       pin_ok_r;
   logic       comb_n;
   crg_state_e state_r;
   logic [2:0] seq_cnt_r;
   logic       clk_div_r;
   logic       in_rst;
   logic       in_rst_r;

   // supply monitor
   crg_supply_mon #(.REF_CYC(REF_CYC), .ANA_CYC(ANA_CYC)) u_mon
   (
      .clk                   (clk),
      .ref_active            (ref_active),
      .ana_present           (ana_present),
      .core_regulator_output (core_regulator_output),
      .mon                   (mon_if.mon)
   );
   assign supply_ok = mon_if.supply_ok;

   // pin synchroniser
   always_ff @(posedge clk)
   begin
      if (reset)
         pin_sync_r <= 2'b00;
      else
         pin_sync_r <= {pin_sync_r[0], reset_pin_n};
   end

   // low pulses shorter than three clocks are not taken
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pin_lo_cnt_r <= 2'h0;
         pin_ok_r     <= 1'b0;
      end
      else if (pin_sync_r[1])
      begin
         pin_lo_cnt_r <= 2'h0;
         pin_ok_r     <= 1'b1;
      end
      else if (32'(pin_lo_cnt_r) < `CRG_PIN_MIN_CYC - 1)
         pin_lo_cnt_r <= pin_lo_cnt_r + 2'h1;
      else
         pin_ok_r <= 1'b0;
   end

   // combined hardware reset, board may tie pin high
   assign comb_n     = pin_ok_r & supply_ok & ~reset;
   assign hw_reset_n = comb_n;

   // asserts at once, releases through the synchroniser
   always_ff @(posedge clk)
   begin
      if (!comb_n)
         rel_sync_r <= '0;
      else
         rel_sync_r <= {rel_sync_r[`CRG_SYNC_STAGES-2:0], 1'b1};
   end
   assign chip_reset_n = comb_n & rel_sync_r[`CRG_SYNC_STAGES-1];
   assign in_rst       = ~chip_reset_n;

   // release sequence: clock enable, then boot
   always_ff @(posedge clk)
   begin
      if (in_rst)
      begin
         state_r   <= CRG_RESET;
         seq_cnt_r <= 3'h0;
      end
      else
         case (state_r)
            CRG_RESET: state_r <= CRG_CLKEN;
            CRG_CLKEN:
            begin
               seq_cnt_r <= seq_cnt_r + 3'h1;
               if (32'(seq_cnt_r) == `CRG_CLKEN_CYC - 1)
                  state_r <= CRG_BOOT;
            end
            CRG_BOOT:  state_r <= CRG_RUN;
            CRG_RUN:   state_r <= CRG_RUN;
            default:   state_r <= CRG_RESET;
         endcase
   end
   assign core_clk_en = (state_r != CRG_RESET);
   assign boot_start  = (state_r == CRG_BOOT);

   // software resets, separate from hardware reset
   always_ff @(posedge clk)
   begin
      if (in_rst)
      begin
         cpu_reset_n    <= 1'b0;
         periph_reset_n <= '0;
      end
      else
      begin
         cpu_reset_n    <= ~cpu_reset_instr;
         periph_reset_n <= ~periph_reset_ctl;
      end
   end

   // rtc power-on detect, untouched by the main reset
   always_ff @(posedge clk)
   begin
      rtc_sync_r <= {rtc_sync_r[0], rtc_por_n};
   end

   // power-lost flag, power-on wins over software clear
   always_ff @(posedge clk)
   begin
      if (!rtc_sync_r[1])
         rtc_power_lost_flag <= 1'b1;
      else if (rtc_flag_clear)
         rtc_power_lost_flag <= 1'b0;
   end

   // clock output divider, held low by local reset, kept toggling in chip reset
   always_ff @(posedge clk)
   begin
      if (reset)
         clk_div_r <= 1'b0;
      else
         clk_div_r <= ~clk_div_r;
   end

   always_ff @(posedge clk)
   begin
      in_rst_r <= in_rst;
   end

   // pad drive: reset overrides the mux
   always_ff @(posedge clk)
   begin
      pins_in_reset <= in_rst;
      clock_output  <= in_rst ? clk_div_r : fn_clock_output;
      spi_cs_n[1]   <= in_rst ? clk_div_r : fn_spi_cs_n[1];
      if (in_rst)
      begin
         ext_mem_cs_n        <= 4'hF;
         ext_mem_byte_mask_n <= 2'h3;
         ext_mem_oe_n        <= 1'b1;
         ext_mem_we_n        <= 1'b1;
         spi_cs_n[3]         <= 1'b1;
         external_flag_out   <= 1'b1;
         rsv_out[5:4]        <= 2'h3;
         // synchronous steps from first reset edge
         spi_cs_n[0]         <= in_rst_r;
         spi_cs_n[2]         <= in_rst_r;
         rsv_out[1:0]        <= {2{~in_rst_r}};
         rsv_out[3:2]        <= 2'h0;
         ext_mem_bank_addr   <= '1;
         ext_mem_addr        <= '0;
      end
      else
      begin
         ext_mem_cs_n        <= fn_ext_mem_cs_n;
         ext_mem_byte_mask_n <= {2{fn_ext_mem_strobes}};
         ext_mem_oe_n        <= fn_ext_mem_strobes;
         ext_mem_we_n        <= fn_ext_mem_strobes;
         spi_cs_n[3]         <= fn_spi_cs_n[3];
         external_flag_out   <= fn_external_flag_out;
         rsv_out             <= 6'h00;
         spi_cs_n[0]         <= fn_spi_cs_n[0];
         spi_cs_n[2]         <= fn_spi_cs_n[2];
         ext_mem_bank_addr   <= fn_ext_mem_bank_addr;
         ext_mem_addr        <= fn_ext_mem_addr;
      end
   end
endmodule
`default_nettype wire

// ==== verification/crg_board_sup.sv ====
// board reset supervisor model driving the reset pin
// assumes go is a one-cycle request from the bench
`timescale 1ns/100ps
`default_nettype none
module crg_board_sup
(
   // request from bench
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [3:0] low_cyc,
   // board reset pin
   output logic            reset_pin_n
);
   logic [3:0] cnt_r = 4'h0;
   // pin idles high, pulled low for low_cyc clocks on request
   always_ff @(posedge clk)
   begin
      if (go)
         cnt_r <= low_cyc;
      else if (cnt_r != 4'h0)
         cnt_r <= cnt_r - 4'h1;
   end
   assign reset_pin_n = (cnt_r == 4'h0);
endmodule
`default_nettype wire

// ==== verification/crg_top_props.sv ====
// checker for the chip reset generation top
// assumes bind to crg_top, one clk domain
`timescale 1ns/100ps
`default_nettype none
module crg_top_props
#(
   parameter int unsigned REF_CYC = 20,
   parameter int unsigned ANA_CYC = 10
)
(
   // clock, reset, causes
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        reset_pin_n,
   input wire logic        rtc_por_n,
   input wire logic        rtc_flag_clear,
   input wire logic        cpu_reset_instr,
   input wire logic [7:0]  periph_reset_ctl,
   // effects
   input wire logic        supply_ok,
   input wire logic        hw_reset_n,
   input wire logic        chip_reset_n,
   input wire logic        core_clk_en,
   input wire logic        boot_start,
   input wire logic        cpu_reset_n,
   input wire logic [7:0]  periph_reset_n,
   input wire logic        rtc_power_lost_flag,
   input wire logic [3:0]  ext_mem_cs_n,
   input wire logic [1:0]  ext_mem_byte_mask_n,
   input wire logic        ext_mem_oe_n,
   input wire logic        ext_mem_we_n,
   input wire logic [20:0] ext_mem_addr,
   input wire logic [1:0]  ext_mem_bank_addr,
   input wire logic [3:0]  spi_cs_n,
   input wire logic        external_flag_out,
   input wire logic        clock_output,
   input wire logic [5:0]  rsv_out
);
   logic rst_d_r;
   // the clock divider holds still while reset stands, so checks
   // resume one edge after reset has been seen low
   always_ff @(posedge clk)
   begin
      rst_d_r <= reset;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset || rst_d_r);
   // chip held in reset for three samples
   sequence s_in_rst;
      !chip_reset_n [*3];
   endsequence
   a_hw_supply: assert property (hw_reset_n |-> supply_ok)
      else $error("hw reset released without supply");
   a_pin_low: assert property (!reset_pin_n [*7] |-> !hw_reset_n)
      else $error("held pin did not reset");
   a_chip_gate: assert property (chip_reset_n |-> hw_reset_n)
      else $error("chip reset released early");
   a_boot_seq: assert property ($rose(chip_reset_n) |->
      ##[0:2] core_clk_en ##[3:6] boot_start ##1 !boot_start)
      else $error("boot sequence wrong");
   a_pads_high: assert property (s_in_rst |=> ext_mem_cs_n == 4'hF
      && ext_mem_byte_mask_n == 2'h3 && ext_mem_oe_n && ext_mem_we_n
      && spi_cs_n[3] && external_flag_out && rsv_out[5:4] == 2'h3)
      else $error("high group not high");
   a_sync_grp: assert property (s_in_rst ##1 !chip_reset_n |=>
      spi_cs_n[0] && spi_cs_n[2] && rsv_out[1:0] == 2'h0
      && ext_mem_bank_addr == 2'h3 && ext_mem_addr == 21'h0)
      else $error("sync group wrong");
   a_clk_toggle: assert property (s_in_rst |->
      clock_output != $past(clock_output)
      && spi_cs_n[1] != $past(spi_cs_n[1]))
      else $error("clock group not toggling");
   a_sw_reset: assert property (cpu_reset_instr |=> !cpu_reset_n
      && ($past(periph_reset_ctl) & periph_reset_n) == 8'h00)
      else $error("software reset not applied");
   a_rtc_flag: assert property ($fell(rtc_power_lost_flag) |->
      $past(rtc_flag_clear) && $past(rtc_por_n))
      else $error("rtc flag lost without clear");
endmodule
bind crg_top crg_top_props #(.REF_CYC(REF_CYC), .ANA_CYC(ANA_CYC))
   u_props (.*);
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the chip reset generation top
// assumes short supply counts and a board supervisor model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk = 0, reset = 1, ref_active = 0, ana_present = 0;
   logic rtc_por_n = 0, rtc_flag_clear = 0, cpu_reset_instr = 0, go = 0;
   logic [11:0] mv = 12'h000;
   logic [7:0] periph = 8'h00;
   logic [3:0] low = 4'h0;
   logic [33:0] fn = 34'h2_A5C3_1E96;
   wire pin_n, supply_ok, hw_reset_n, chip_reset_n, boot_start;
   wire cpu_reset_n, rtc_power_lost_flag;
   wire [7:0] periph_reset_n;
   wire [3:0] ext_mem_cs_n, spi_cs_n;
   wire [20:0] ext_mem_addr;
   wire [1:0] ext_mem_bank_addr;
   wire [5:0] rsv_out;
   int err_count = 0;
   int total_checks = 0;
   // 250 MHz clock
   always #2 clk = ~clk;
   crg_board_sup sup (.clk(clk), .go(go), .low_cyc(low), .reset_pin_n(pin_n));
   crg_top #(.REF_CYC(20), .ANA_CYC(10)) DUT (.clk(clk), .reset(reset),
      .reset_pin_n(pin_n), .ref_active(ref_active), .ana_present(ana_present),
      .core_regulator_output(mv), .rtc_por_n(rtc_por_n),
      .rtc_flag_clear(rtc_flag_clear),
      .rtc_power_lost_flag(rtc_power_lost_flag),
      .cpu_reset_instr(cpu_reset_instr), .periph_reset_ctl(periph),
      .cpu_reset_n(cpu_reset_n), .periph_reset_n(periph_reset_n),
      .supply_ok(supply_ok), .hw_reset_n(hw_reset_n),
      .chip_reset_n(chip_reset_n), .core_clk_en(), .boot_start(boot_start),
      .fn_clock_output(fn[0]), .fn_ext_mem_strobes(fn[1]),
      .fn_ext_mem_cs_n(fn[5:2]), .fn_ext_mem_addr(fn[26:6]),
      .fn_ext_mem_bank_addr(fn[28:27]), .fn_spi_cs_n(fn[32:29]),
      .fn_external_flag_out(fn[33]), .ext_mem_cs_n(ext_mem_cs_n),
      .ext_mem_byte_mask_n(), .ext_mem_oe_n(), .ext_mem_we_n(),
      .ext_mem_addr(ext_mem_addr), .ext_mem_bank_addr(ext_mem_bank_addr),
      .spi_cs_n(spi_cs_n), .external_flag_out(), .clock_output(),
      .rsv_out(rsv_out), .pins_in_reset());
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // bounded wait for the boot pulse
   task automatic wait_boot(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge clk);
         if (boot_start === 1'b1)
            return;
      end
      err_count++;
      finish_test;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // supplies come up, pads follow the muxes
   task automatic t_power;
      @(posedge clk);
      ref_active <= 1;
      ana_present <= 1;
      mv <= 12'h3E8;
      cyc(8);
      chk(supply_ok, 0);
      wait_boot(80);
      cyc(3);
      chk(ext_mem_addr, fn[26:6]);
   endtask
   // rtc flag set by its own power-on, cleared by software
   task automatic t_rtc;
      chk(rtc_power_lost_flag, 1);
      @(posedge clk);
      rtc_flag_clear <= 1;
      @(posedge clk);
      rtc_flag_clear <= 0;
      cyc(2);
      chk(rtc_power_lost_flag, 0);
   endtask
   // software resets leave hardware reset alone
   task automatic t_sw;
      @(posedge clk);
      cpu_reset_instr <= 1;
      periph <= 8'hA5;
      cyc(3);
      chk(cpu_reset_n, 0);
      chk(periph_reset_n, 8'h5A);
      chk(hw_reset_n, 1);
      @(posedge clk);
      cpu_reset_instr <= 0;
      periph <= 8'h00;
      cyc(3);
      chk(periph_reset_n, 8'hFF);
   endtask
   // regulator at threshold drops supply and resets pads
   task automatic t_supply;
      @(posedge clk);
      mv <= 12'h384;
      cyc(8);
      chk(supply_ok, 0);
      chk(hw_reset_n, 0);
      chk(ext_mem_addr, 0);
      chk(ext_mem_cs_n, 4'hF);
      chk(spi_cs_n[2], 1);
      @(posedge clk);
      mv <= 12'h385;
      wait_boot(80);
   endtask
   // short pin pulse ignored, long one resets but spares rtc
   task automatic t_pin(input logic [3:0] n, input logic exp);
      @(posedge clk);
      low <= n;
      go <= 1;
      @(posedge clk);
      go <= 0;
      cyc(7);
      chk(hw_reset_n, exp);
      chk(rtc_power_lost_flag, 0);
      if (exp === 1'b0)
         wait_boot(40);
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 0;
      rtc_por_n <= 1;
      t_power;
      t_rtc;
      t_sw;
      t_supply;
      t_pin(4'h2, 1'b1);
      t_pin(4'h9, 1'b0);
      finish_test;
   end
endmodule
`default_nettype wire
